/* File: sfc_engine.sv */
// Span fill and copy engine: APB drawing registers, host frame-buffer
// write port, and a 64-bit frame-buffer memory port.
// Assumes memory holds mem_ack high for one cycle per accepted request.
`timescale 1ns/1ps

// Contract
// RULE_01: Transparent fill write to frame buffer draws masked span up to 2K pixels.
// RULE_02: Fill data carries count minus one in 10:0, address low bits 17:16.
// RULE_03: Transparent fill writes foreground where pattern bit is 1, else untouched.
// RULE_04: The 32-pixel pattern repeats until the pixel count is covered.
// RULE_05: Fills apply raster op 3:0; destination format 9:8, byte 11:10.
// RULE_06: Pattern from pattern data register, colour from foreground register.
// RULE_07: Opaque fill is bitonal with any raster op, no per-pixel masking.
// RULE_08: Two host writes in copy mode copy up to 64 bytes source to destination.
// RULE_09: Host writes source address with read mask, then destination with write mask.
// RULE_10: 32-bpp mask in data 15:0, upper bits and byte enables ignored.
// RULE_11: The 64-byte copy buffer bounds every copy span.
// RULE_12: Span limits: 8-bpp 32 masked pixels, 32-bpp 16 pixels.
// RULE_13: Software zeroes depth and byte fields for 8-bpp copies.
// RULE_14: Software sets depth seven and byte zero for 24-bpp copies.
// RULE_15: First copy write reads masked source, aligns, fills buffer bottom up.
// RULE_16: Second write drains buffer bottom up, writing where destination mask allows.
// RULE_17: Destination write applies plane mask and the raster operation.
// RULE_18: Copy takes shift 3:0, source format 10:8, source byte 12:11.
// RULE_19: Copies step addresses upward forward, downward backward.
// RULE_20: Source data is shifted so any alignment copies correctly.
// RULE_21: Negative pixel shift gives backward copy, non-negative gives forward.
// RULE_22: Addresses decrement per quadword backward and increment forward.
// RULE_23: A hidden 64-bit residue of the last source quadword feeds the shifter.
// RULE_24: Copy buffer stays unchanged between source and destination writes.
module sfc_engine
    import sfc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host frame-buffer writes
    input  wire logic        fb_valid,
    output logic             fb_ready,
    input  wire logic [31:0] fb_addr,
    input  wire logic [31:0] fb_data,
    input  wire logic [3:0]  fb_be,
    // Frame-buffer memory port
    output logic             mem_req,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [7:0]  mem_be,
    output logic      [63:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [63:0] mem_rdata,
    // Bitmap format selections for the pixel path
    output logic      [1:0]  dst_fmt,
    output logic      [1:0]  dst_byte,
    output logic      [2:0]  src_fmt,
    output logic      [1:0]  src_byte
);

    // Byte enables of one copy quadword from the span mask
    function automatic logic [7:0] qword_be(input logic [31:0] m,
                                            input logic [2:0] q,
                                            input logic fb32);
        logic [1:0] pair;
        pair = 2'h0;
        if (fb32) begin
            pair     = m[{q, 1'b0} +: 2];
            qword_be = {{4{pair[1]}}, {4{pair[0]}}};
        end else begin
            qword_be = q[2] ? 8'h00 : m[{q[1:0], 3'h0} +: 8];
        end
    endfunction

    // Drawing registers
    logic [31:0] mode_q, rop_q, fg_q, bg_q, plane_q, pixmask_q, pattern_q;
    logic [3:0]  shift_q;
    // Span sequencer state
    sfc_state_e  state_q;
    logic [31:0] base_q;
    logic [31:0] mask_q;
    logic [CNT_W-1:0] cnt_q, idx_q;
    logic [2:0]  q_q;
    logic [63:0] wdata_q;
    logic [63:0] residue_q;
    logic [63:0] buf_q [BUF_DEPTH];

    // Decoded controls
    logic        fb32, backward, opaque;
    logic [1:0]  mode;
    logic        wr_en, rd_en;
    logic        pat_bit, need_wr;
    logic [31:0] pix_addr, color, qaddr;
    logic [63:0] src64, fill_new, copy_new, shifted;
    logic [7:0]  pix_be, cur_be;
    logic [2:0]  qlast;
    logic        fill_last, q_last;
    logic        take_fill, take_src, take_dst;

    // Register field decode
    assign mode     = mode_q[MODE_LSB +: 2];
    assign fb32     = mode_q[FB32_BIT];
    assign opaque   = (mode == MODE_OFILL);
    assign backward = shift_q[3];                                        // RULE_21
    assign dst_fmt  = rop_q[DST_FMT_LSB +: 2];                           // RULE_05
    assign dst_byte = rop_q[DST_BYTE_LSB +: 2];
    assign src_fmt  = mode_q[SRC_FMT_LSB +: 3];                          // RULE_18
    assign src_byte = mode_q[SRC_BYTE_LSB +: 2];

    // APB: zero wait states, unmapped offsets error and read zero
    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & penable & ~pwrite;

    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            OFS_MODE:    prdata = mode_q;
            OFS_ROP:     prdata = rop_q;
            OFS_FG:      prdata = fg_q;
            OFS_BG:      prdata = bg_q;
            OFS_PLANE:   prdata = plane_q;
            OFS_PIXMASK: prdata = pixmask_q;
            OFS_PATTERN: prdata = pattern_q;
            OFS_SHIFT:   prdata = {28'h0, shift_q};
            OFS_STATUS:  prdata = {30'h0, state_q == ST_CWAIT, state_q != ST_IDLE};
            default:     pslverr = psel & penable;
        endcase
    end

    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= RST_REG;
            rop_q     <= {28'h0, ROP_COPY};
            fg_q      <= RST_REG;
            bg_q      <= RST_REG;
            plane_q   <= RST_REG;
            pixmask_q <= RST_REG;
            pattern_q <= RST_REG;
            shift_q   <= 4'h0;
        end else if (wr_en) begin
            case (paddr)
                OFS_MODE:    mode_q    <= pwdata;
                OFS_ROP:     rop_q     <= pwdata;
                OFS_FG:      fg_q      <= pwdata;
                OFS_BG:      bg_q      <= pwdata;
                OFS_PLANE:   plane_q   <= pwdata;
                OFS_PIXMASK: pixmask_q <= pwdata;
                OFS_PATTERN: pattern_q <= pwdata;
                OFS_SHIFT:   shift_q   <= pwdata[3:0];
                default:     ;
            endcase
        end
    end

    // Host port: accepted only while idle or holding a copy source
    assign fb_ready  = (state_q == ST_IDLE) || (state_q == ST_CWAIT);
    assign take_fill = fb_valid && (state_q == ST_IDLE) && (mode != MODE_COPY);
    assign take_src  = fb_valid && (state_q == ST_IDLE) && (mode == MODE_COPY);
    assign take_dst  = fb_valid && (state_q == ST_CWAIT);

    // Fill pixel path; pattern bit wraps every 32 pixels
    assign pat_bit  = pattern_q[idx_q[4:0]];                             // RULE_04 RULE_06
    assign need_wr  = opaque | pat_bit;                                  // RULE_03 RULE_07
    assign pix_addr = fb32 ? base_q + {19'h0, idx_q, 2'h0}
                           : base_q + {21'h0, idx_q};
    assign pix_be   = fb32 ? (pix_addr[2] ? 8'hF0 : 8'h0F)
                           : (8'h01 << pix_addr[2:0]);
    assign color    = (opaque && !pat_bit) ? bg_q : fg_q;                // RULE_07
    assign src64    = fb32 ? {color, color} : {8{color[7:0]}};
    assign fill_new = sfc_rop(rop_q[ROP_LSB +: 4], src64, mem_rdata);    // RULE_05
    assign fill_last = (idx_q == cnt_q);

    // Copy quadword path
    assign qlast  = fb32 ? QLAST_32BPP : QLAST_8BPP;                     // RULE_11 RULE_12
    assign q_last = (q_q == qlast);
    assign cur_be = qword_be(mask_q, q_q, fb32);                         // RULE_10
    assign qaddr  = backward ? {base_q[31:3] - {26'h0, q_q}, 3'h0}       // RULE_19 RULE_22
                             : {base_q[31:3] + {26'h0, q_q}, 3'h0};
    assign copy_new = sfc_rop(rop_q[ROP_LSB +: 4], buf_q[q_q], mem_rdata);

    // Merged with the old destination so masked planes keep their bits
    function automatic logic [63:0] plane_merge(input logic [63:0] n,
                                                input logic [63:0] d,
                                                input logic [31:0] pm);
        plane_merge = (n & {pm, pm}) | (d & ~{pm, pm});
    endfunction

    sfc_byte_shifter u_shift (
        .new_qw  (mem_rdata),
        .residue (residue_q),
        .shift   (shift_q),
        .aligned (shifted)                                               // RULE_20 RULE_23
    );

    // Memory request decode; reads skip empty masked quadwords
    always_comb begin
        mem_req  = 1'b0;
        mem_we   = 1'b0;
        mem_addr = 32'h0000_0000;
        mem_be   = 8'h00;
        case (state_q)
            ST_FRD: begin
                mem_req  = need_wr;
                mem_addr = {pix_addr[31:3], 3'h0};
                mem_be   = pix_be;
            end

            ST_FWR: begin
                mem_req  = 1'b1;
                mem_we   = 1'b1;
                mem_addr = {pix_addr[31:3], 3'h0};
                mem_be   = pix_be;
            end

            ST_CSRD, ST_CDRD: begin
                mem_req  = (cur_be != 8'h00);                            // RULE_15
                mem_addr = qaddr;
                mem_be   = cur_be;
            end

            ST_CDWR: begin
                mem_req  = 1'b1;
                mem_we   = 1'b1;
                mem_addr = qaddr;
                mem_be   = cur_be;                                       // RULE_16
            end

            default: ;
        endcase
    end

    assign mem_wdata = wdata_q;

    // Sequencer for fills and both halves of a copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            base_q  <= RST_REG;
            mask_q  <= RST_REG;
            cnt_q   <= '0;
            idx_q   <= '0;
            q_q     <= 3'h0;
            wdata_q <= 64'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take_fill) begin
                        base_q  <= {fb_addr[31:2], fb_data[ALO_LSB +: 2]};   // RULE_02
                        cnt_q   <= fb_data[CNT_LSB +: CNT_W];                // RULE_01
                        idx_q   <= '0;
                        state_q <= ST_FRD;
                    end else if (take_src) begin
                        base_q  <= fb_addr;                                  // RULE_08
                        mask_q  <= fb32 ? {16'h0, fb_data[15:0]} : fb_data;
                        q_q     <= 3'h0;
                        state_q <= ST_CSRD;
                    end
                end

                ST_FRD: begin
                    if (!need_wr) begin
                        idx_q   <= idx_q + 1'b1;
                        state_q <= fill_last ? ST_IDLE : ST_FRD;
                    end else if (mem_ack) begin
                        wdata_q <= plane_merge(fill_new, mem_rdata, plane_q);
                        state_q <= ST_FWR;
                    end
                end

                ST_FWR: begin
                    if (mem_ack) begin
                        idx_q   <= idx_q + 1'b1;
                        state_q <= fill_last ? ST_IDLE : ST_FRD;     // RULE_04
                    end
                end

                ST_CSRD: begin
                    if ((cur_be == 8'h00) || mem_ack) begin
                        q_q     <= q_q + 3'h1;
                        state_q <= q_last ? ST_CWAIT : ST_CSRD;
                    end
                end

                ST_CWAIT: begin
                    if (take_dst) begin
                        base_q  <= fb_addr;
                        mask_q  <= fb32 ? {16'h0, fb_data[15:0]} : fb_data;
                        q_q     <= 3'h0;
                        state_q <= ST_CDRD;
                    end
                end

                ST_CDRD: begin
                    if (cur_be == 8'h00) begin
                        q_q     <= q_q + 3'h1;
                        state_q <= q_last ? ST_IDLE : ST_CDRD;
                    end else if (mem_ack) begin
                        wdata_q <= plane_merge(copy_new, mem_rdata, plane_q); // RULE_17
                        state_q <= ST_CDWR;
                    end
                end

                ST_CDWR: begin
                    if (mem_ack) begin
                        q_q     <= q_q + 3'h1;
                        state_q <= q_last ? ST_IDLE : ST_CDRD;
                    end
                end

                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Copy buffer fill, bottom entry first; untouched outside source reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            residue_q <= 64'h0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_q[i] <= 64'h0;
            end
        end else if (take_src) begin
            residue_q <= 64'h0;
        end else if (state_q == ST_CSRD && cur_be != 8'h00 && mem_ack) begin
            buf_q[q_q] <= shifted;                                       // RULE_15 RULE_24
            residue_q  <= mem_rdata;                                     // RULE_23
        end
    end

    // Byte enables of host writes carry no meaning here
    logic be_unused;
    assign be_unused = ^fb_be;                                           // RULE_10

endmodule

/* File: sfc_pkg.sv */
// Package for the frame-buffer span fill and copy engine.
// Assumes an APB register slave and one 64-bit frame-buffer memory port.
package sfc_pkg;

    // APB register byte offsets
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_ROP     = 8'h04;
    localparam logic [7:0] OFS_FG      = 8'h08;
    localparam logic [7:0] OFS_BG      = 8'h0C;
    localparam logic [7:0] OFS_PLANE   = 8'h10;
    localparam logic [7:0] OFS_PIXMASK = 8'h14;
    localparam logic [7:0] OFS_PATTERN = 8'h18;
    localparam logic [7:0] OFS_SHIFT   = 8'h1C;
    localparam logic [7:0] OFS_STATUS  = 8'h20;

    // Engine mode register fields
    localparam int MODE_LSB     = 0;
    localparam int FB32_BIT     = 4;
    localparam int SRC_FMT_LSB  = 8;
    localparam int SRC_BYTE_LSB = 11;
    localparam logic [1:0] MODE_TFILL = 2'h0;
    localparam logic [1:0] MODE_OFILL = 2'h1;
    localparam logic [1:0] MODE_COPY  = 2'h2;

    // Raster operation register fields
    localparam int ROP_LSB      = 0;
    localparam int DST_FMT_LSB  = 8;
    localparam int DST_BYTE_LSB = 10;

    // Fill write-data fields
    localparam int CNT_LSB  = 0;
    localparam int CNT_W    = 11;
    localparam int ALO_LSB  = 16;

    // Copy buffer: 64 bytes as eight quadwords
    localparam int BUF_DEPTH  = 8;
    localparam logic [2:0] QLAST_32BPP = 3'h7;
    localparam logic [2:0] QLAST_8BPP  = 3'h3;

    // Reset values
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam logic [3:0]  ROP_COPY = 4'h3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FRD, ST_FWR, ST_CSRD, ST_CWAIT, ST_CDRD, ST_CDWR
    } sfc_state_e;

    // Boolean raster op, code bit picked by inverted source and destination
    function automatic logic [63:0] sfc_rop(input logic [3:0] code,
                                            input logic [63:0] s,
                                            input logic [63:0] d);
        sfc_rop = ({64{code[0]}} & s & d) | ({64{code[1]}} & s & ~d)
                | ({64{code[2]}} & ~s & d) | ({64{code[3]}} & ~s & ~d);
    endfunction

endpackage

/* File: sfc_byte_shifter.sv */
// Byte shifter aligning source quadwords to the destination.
// Assumes the residue holds the previous source quadword read.
`timescale 1ns/1ps
module sfc_byte_shifter (
    input  wire logic [63:0] new_qw,
    input  wire logic [63:0] residue,
    input  wire logic [3:0]  shift,
    output logic      [63:0] aligned
);
    logic [127:0] cat;
    logic [127:0] rot;
    logic [6:0]   bits;

    // Positive shift rotates right, negative rotates left
    assign cat  = {new_qw, residue};
    assign bits = shift[3] ? {~shift + 4'h1, 3'h0} : {shift, 3'h0};
    assign rot  = shift[3] ? ((cat << bits) | (cat >> (8'h80 - {1'b0, bits})))
                           : ((cat >> bits) | (cat << (8'h80 - {1'b0, bits})));
    // Take the slot where the new data sat before rotating
    assign aligned = rot[127:64];
endmodule

/* File: sfc_engine_asserts.sv */
// Port-level checker for the span fill and copy engine.
// Assumes the bench keeps the pattern and mode steady while a span runs.
`timescale 1ns/1ps
module sfc_engine_asserts
    import sfc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        fb_valid,
    input wire logic        fb_ready,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic [1:0]  dst_fmt,
    input wire logic [1:0]  dst_byte,
    input wire logic [2:0]  src_fmt,
    input wire logic [1:0]  src_byte
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of the fields that decide what the engine may do
    logic [1:0] mode_q;
    logic       pat0_q;
    logic       pend_q;
    wire        apw     = psel && penable && pwrite;
    wire        taken   = fb_valid && fb_ready;
    wire        is_copy = (mode_q == MODE_COPY);
    wire [1:0]  w_dfmt  = pwdata[9:8];
    wire [1:0]  w_dbyte = pwdata[11:10];
    wire [2:0]  w_sfmt  = pwdata[10:8];
    wire [1:0]  w_sbyte = pwdata[12:11];

    // Pending toggles per copy half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            pat0_q <= 1'b1;
            pend_q <= 1'b0;
        end else begin
            if (apw && paddr == OFS_MODE) mode_q <= pwdata[1:0];
            if (apw && paddr == OFS_PATTERN) pat0_q <= (pwdata == 32'h0);
            if (taken && is_copy) pend_q <= !pend_q;
        end
    end

    property p_fill_busy;
        taken && !is_copy |=> !fb_ready;
    endproperty
    property p_transp;
        mem_req && mode_q != MODE_OFILL && !is_copy && pat0_q |-> !mem_we;
    endproperty
    property p_src_nowr;
        mem_req && is_copy && pend_q |-> !mem_we;
    endproperty
    property p_align;
        mem_req |-> mem_addr[2:0] == 3'h0;
    endproperty
    property p_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
    endproperty
    property p_dfmt;
        apw && paddr == OFS_ROP |=> dst_fmt == $past(w_dfmt) && dst_byte == $past(w_dbyte);
    endproperty
    property p_sfmt;
        apw && paddr == OFS_MODE |=> src_fmt == $past(w_sfmt) && src_byte == $past(w_sbyte);
    endproperty
    property p_rd_wr;
        !is_copy && mem_req && $rose(mem_we) |-> $past(mem_ack);
    endproperty

    a_fill_busy: assert property (p_fill_busy) else $error("fill not busy");
    a_transp: assert property (p_transp) else $error("write with empty pattern");
    a_src_nowr: assert property (p_src_nowr) else $error("write in source phase");
    a_align: assert property (p_align) else $error("unaligned quadword");
    a_hold: assert property (p_hold) else $error("request changed before ack");
    a_dfmt: assert property (p_dfmt) else $error("destination fields wrong");
    a_sfmt: assert property (p_sfmt) else $error("source fields wrong");
    a_rd_wr: assert property (p_rd_wr) else $error("fill write without read");

    c_fill: cover property (taken && !is_copy);
    c_copy: cover property (taken && is_copy && pend_q);
    c_wr: cover property (mem_req && mem_we && mem_ack);
endmodule

bind sfc_engine sfc_engine_asserts sfc_engine_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .fb_valid(fb_valid), .fb_ready(fb_ready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .dst_fmt(dst_fmt), .dst_byte(dst_byte), .src_fmt(src_fmt), .src_byte(src_byte)
);

/* File: sfc_mem_model.sv */
// Frame-buffer memory model: 64 quadwords, ack after lat idle cycles.
// Assumes requests hold until their one-cycle ack.
`timescale 1ns/1ps
module sfc_mem_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [7:0]  mem_be,
    input wire logic [63:0] mem_wdata,
    input wire logic [3:0]  lat,
    output logic            mem_ack,
    output logic     [63:0] mem_rdata
);
    logic [63:0] mem [0:63];
    logic [31:0] last_wr;
    logic [3:0]  cnt;

    // Each 32-bit word starts as A000_0000 plus its word index
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = {32'hA000_0000 | 32'(2 * i + 1), 32'hA000_0000 | 32'(2 * i)};
        end
    end

    // Read data toggles outside read acks so stale data never looks valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            mem_rdata <= 64'h0;
            last_wr <= 32'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack && cnt != lat) begin
                cnt <= cnt + 4'h1;
            end else if (mem_req && !mem_ack) begin
                cnt <= 4'h0;
                mem_ack <= 1'b1;
                if (!mem_we) mem_rdata <= mem[mem_addr[8:3]];
                else last_wr <= mem_addr;
                for (int b = 0; b < 8; b++) begin
                    if (mem_we && mem_be[b]) mem[mem_addr[8:3]][8*b +: 8] <= mem_wdata[8*b +: 8];
                end
            end
        end
    end
endmodule

/* File: sfc_engine_bench.sv */
// Self-checking bench: APB register tasks, host frame-buffer writes.
// Assumes the memory model starts each word at A000_0000 plus its index.
`timescale 1ns/1ps
module sfc_engine_bench;
    import sfc_pkg::*;
    localparam logic [31:0] FG = 32'hC0DE_F00D;
    localparam logic [31:0] BG = 32'h0F0F_0F0F;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, fb_addr = 32'h0, fb_data = 32'h0, prdata, rdat, a, v;
    logic        pready, pslverr, fb_valid = 1'b0, fb_ready, mem_req, mem_we, mem_ack, rerr;
    logic [31:0] mem_addr;
    logic [7:0]  mem_be;
    logic [63:0] mem_wdata, mem_rdata;
    logic [3:0]  lat = 4'h0;
    int          failures = 0, n_tests = 0, cycles = 0;

    always #2 pclk = ~pclk;

    sfc_engine sfc_engine_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fb_valid(fb_valid), .fb_ready(fb_ready), .fb_addr(fb_addr),
        .fb_data(fb_data), .fb_be(4'h0), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .dst_fmt(), .dst_byte(), .src_fmt(), .src_byte());
    sfc_mem_model sfc_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    function automatic logic [31:0] iv(input logic [31:0] x);
        return 32'hA000_0000 | (x >> 2);
    endfunction
    function automatic logic [31:0] px(input logic [31:0] x);
        return x[2] ? sfc_mem_model_inst.mem[x[8:3]][63:32] : sfc_mem_model_inst.mem[x[8:3]][31:0];
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer, then an idle edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Host write, then wait until the engine takes requests again
    task automatic fbw(input logic [31:0] ad, input logic [31:0] d);
        fb_valid <= 1'b1;
        fb_addr <= ad;
        fb_data <= d;
        do @(posedge pclk); while (fb_ready !== 1'b1);
        fb_valid <= 1'b0;
        do @(posedge pclk); while (fb_ready !== 1'b1);
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard, far above the run length
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("idle ready", 32'h1, {31'h0, fb_ready});
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", (i == 1) ? 32'(ROP_COPY) : 32'h0, rdat);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped read", 32'h0, rdat);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", 32'h0, rdat);
        apb(1'b1, OFS_PIXMASK, 32'h1234_ABCD);
        apb(1'b0, OFS_PIXMASK, 32'h0);
        chk("pixel mask", 32'h1234_ABCD, rdat);
        fbw(32'h1A8, 32'h7);
        chk("empty pattern", iv(32'h1A8), px(32'h1A8));
        // Transparent fill of 33 pixels, pattern repeats past pixel 32
        apb(1'b1, OFS_PLANE, 32'hFFFF_FFFF);
        apb(1'b1, OFS_MODE, 32'h10);
        apb(1'b1, OFS_FG, FG);
        apb(1'b1, OFS_PATTERN, 32'h3);
        fbw(32'h100, 32'h20);
        for (int p = 0; p < 36; p++) begin
            a = 32'(32'h100 + 4 * p);
            chk("fill pixel", (p < 33 && p % 32 < 2) ? FG : iv(a), px(a));
        end
        // 8-bpp fill with start byte taken from data bits 17:16
        apb(1'b1, OFS_MODE, 32'h0);
        fbw(32'h1A0, 32'h0003_0000);
        chk("byte fill", (iv(32'h1A0) & 32'h00FF_FFFF) | {FG[7:0], 24'h0}, px(32'h1A0));
        chk("byte neighbour", iv(32'h1A4), px(32'h1A4));
        // Opaque fill with AND, slow memory, pixel mask ignored
        lat <= 4'h3;
        apb(1'b1, OFS_MODE, 32'h11);
        apb(1'b1, OFS_ROP, 32'h1);
        apb(1'b1, OFS_BG, BG);
        fbw(32'h040, 32'h2);
        for (int p = 0; p < 4; p++) begin
            a = 32'(32'h40 + 4 * p);
            v = iv(a);
            chk("opaque pixel", p < 2 ? FG & v : (p == 2 ? BG & v : v), px(a));
        end
        apb(1'b1, OFS_ROP, 32'h3);
        // Forward copy, upper mask bits set and must be ignored
        apb(1'b1, OFS_MODE, 32'h712);
        apb(1'b1, OFS_PLANE, 32'hFFFF_0000);
        fbw(32'h080, 32'hFFFF_000F);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("copy pending", 32'h1, {31'h0, rdat[1]});
        fbw(32'h1C0, 32'hFFFF_0005);
        for (int p = 0; p < 4; p++) begin
            a = 32'(32'h1C0 + 4 * p);
            v = iv(a);
            chk("copy pixel", p % 2 == 0 ? (iv(a - 32'h140) & 32'hFFFF_0000) | (v & 32'h0000_FFFF) : v, px(a));
        end
        // Backward copy of two quadwords steps addresses down
        apb(1'b1, OFS_MODE, 32'h2);
        apb(1'b1, OFS_SHIFT, 32'h8);
        fbw(32'h0B8, 32'hFFFF);
        fbw(32'h1F8, 32'hFFFF);
        chk("last write", 32'h1F0, sfc_mem_model_inst.last_wr);
        summarize();
    end
endmodule
